// >>> frp_pkg.sv
// package for the fault response policy block
package frp_pkg;
	// ************************************
	// configuration byte layout
	// ************************************
	localparam int RESP_HI  = 7;
	localparam int RESP_LO  = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] TIMING_CMD = 8'hD2;
	localparam logic [15:0] UNIT_RESET = 16'h0001;

	// ************************************
	// codes
	// ************************************
	localparam logic [1:0] RESP_IGNORE  = 2'h0;
	localparam logic [1:0] RESP_DELAYED = 2'h1;
	localparam logic [1:0] RESP_SHUTDN  = 2'h2;
	localparam logic [1:0] RESP_RESUME  = 2'h3;
	localparam logic [2:0] RETRY_NONE   = 3'h0;
	localparam logic [2:0] RETRY_MAX_N  = 3'h5;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ************************************
	// states
	// ************************************
	typedef enum logic [2:0] {
		FRP_RUN     = 3'b000,
		FRP_GRACE   = 3'b001,
		FRP_WAIT    = 3'b010,
		FRP_TRY     = 3'b011,
		FRP_LATCHED = 3'b100,
		FRP_HOLD    = 3'b101
	} frp_state_e;
endpackage : frp_pkg

// >>> frp_tmr_if.sv
// interface between the policy machine and its delay timer
`timescale 1ns/100ps
interface frp_tmr_if;
	logic        start;
	logic        clear;
	logic [2:0]  exp;
	logic [15:0] unit;
	logic        done;
	modport ctrl (output start, output clear, output exp, output unit,
		input done);
	modport tmr  (input start, input clear, input exp, input unit,
		output done);
endinterface : frp_tmr_if

// >>> frp_delay_timer.sv
// delay timer: 2**exp units of unit cycles each
`timescale 1ns/100ps
module frp_delay_timer #(
	parameter int UNIT_W = 16
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	frp_tmr_if.tmr    t
);
	logic [UNIT_W-1:0] tick;
	logic [UNIT_W-1:0] next_tick;
	logic [7:0]        units;
	logic [7:0]        next_units;
	logic              run;
	logic              next_run;
	logic              done;
	logic              next_done;

	always_comb begin
		next_tick  = tick;
		next_units = units;
		next_run   = run;
		next_done  = 1'b0;
		if (t.clear) begin
			next_run = 1'b0;
		end else if (t.start) begin
			next_run   = 1'b1;
			next_tick  = '0;
			next_units = 8'(8'h01 << t.exp);
		end else if (run) begin
			// unit of zero is treated as one cycle
			if (tick + 1'b1 >= t.unit || t.unit == '0) begin
				next_tick = '0;
				if (units == 8'h01) begin
					next_run  = 1'b0;
					next_done = 1'b1;
				end else begin
					next_units = units - 8'h01;
				end
			end else begin
				next_tick = tick + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tick  <= '0;
			units <= 8'h00;
			run   <= 1'b0;
			done  <= 1'b0;
		end else begin
			tick  <= next_tick;
			units <= next_units;
			run   <= next_run;
			done  <= next_done;
		end
	end

	assign t.done = done;
endmodule : frp_delay_timer

// >>> frp_policy.sv
// fault response policy for one monitored fault
`timescale 1ns/100ps
module frp_policy (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       fault_pin,
	input  wire logic       cfg_we,
	input  wire logic [7:0] cfg_cmd,
	input  wire logic [15:0] cfg_wdata,
	input  wire logic       cmd_on,
	input  wire logic       bias_ok,
	input  wire logic       other_fault,
	input  wire logic       fault_clear,
	output logic [7:0]      cfg_rdata,
	output logic            out_enable,
	output logic            fault_latched,
	output logic [2:0]      attempts,
	output logic [2:0]      state_out
);
	// ************************************
	// pin synchroniser
	// ************************************
	logic fault_s1;
	logic fault_s2;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fault_s1 <= 1'b0;
			fault_s2 <= 1'b0;
		end else begin
			fault_s1 <= fault_pin;
			fault_s2 <= fault_s1;
		end
	end

	// ************************************
	// configuration registers
	// ************************************
	logic [7:0]  cfg;
	logic [7:0]  next_cfg;
	logic [15:0] unit;
	logic [15:0] next_unit;

	always_comb begin
		next_cfg  = cfg;
		next_unit = unit;
		if (cfg_we && cfg_cmd == frp_pkg::TIMING_CMD) begin
			next_unit = cfg_wdata;
		end else if (cfg_we) begin
			next_cfg = cfg_wdata[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg  <= frp_pkg::CFG_RESET;
			unit <= frp_pkg::UNIT_RESET;
		end else begin
			cfg  <= next_cfg;
			unit <= next_unit;
		end
	end

	logic [1:0] resp;
	logic [2:0] retry;
	assign resp  = cfg[frp_pkg::RESP_HI:frp_pkg::RESP_LO];
	assign retry = cfg[frp_pkg::RETRY_HI:frp_pkg::RETRY_LO];

	// ************************************
	// delay timer
	// ************************************
	frp_tmr_if tif ();
	frp_delay_timer #(.UNIT_W(16)) u_tmr (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.t       (tif)
	);

	// ************************************
	// policy machine
	// ************************************
	frp_pkg::frp_state_e state;
	frp_pkg::frp_state_e next_state;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic       en;
	logic       next_en;
	logic       latch;
	logic       next_latch;
	logic       tstart;
	logic       tclear;
	logic       stop_all;

	// 111 values 110 also treated as limited (6 attempts)
	function automatic logic tries_left(input logic [2:0] r,
		input logic [2:0] c);
		tries_left = (r == frp_pkg::RETRY_FOREVER) || (c < r);
	endfunction : tries_left

	assign stop_all = !cmd_on || !bias_ok || other_fault;

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_en    = en;
		next_latch = latch;
		tstart     = 1'b0;
		tclear     = 1'b0;
		if (fault_clear) begin
			next_state = frp_pkg::FRP_RUN;
			next_cnt   = 3'h0;
			next_latch = 1'b0;
			next_en    = 1'b1;
			tclear     = 1'b1;
		end else begin
			case (state)
				frp_pkg::FRP_RUN: begin
					next_en = 1'b1;
					if (fault_s2) begin
						case (resp)
							frp_pkg::RESP_IGNORE: next_en = 1'b1;
							frp_pkg::RESP_DELAYED: begin
								tstart     = 1'b1;
								next_state = frp_pkg::FRP_GRACE;
							end
							frp_pkg::RESP_SHUTDN: begin
								next_en    = 1'b0;
								next_latch = 1'b1;
								tstart     = 1'b1;
								next_state = frp_pkg::FRP_WAIT;
							end
							default: begin
								next_en    = 1'b0;
								next_state = frp_pkg::FRP_HOLD;
							end
						endcase
					end
				end
				frp_pkg::FRP_GRACE: begin
					if (tif.done) begin
						if (fault_s2) begin
							next_en    = 1'b0;
							next_latch = 1'b1;
							tstart     = 1'b1;
							next_state = frp_pkg::FRP_WAIT;
						end else begin
							next_state = frp_pkg::FRP_RUN;
						end
					end
				end
				frp_pkg::FRP_WAIT: begin
					if (retry == frp_pkg::RETRY_NONE) begin
						tclear     = 1'b1;
						next_state = frp_pkg::FRP_LATCHED;
					end else if (retry == frp_pkg::RETRY_FOREVER &&
						stop_all) begin
						tclear     = 1'b1;
						next_state = frp_pkg::FRP_LATCHED;
					end else if (tif.done) begin
						if (tries_left(retry, cnt)) begin
							next_en    = 1'b1;
							if (retry != frp_pkg::RETRY_FOREVER) begin
								next_cnt = cnt + 3'h1;
							end
							tstart     = 1'b1;
							next_state = frp_pkg::FRP_TRY;
						end else begin
							next_state = frp_pkg::FRP_LATCHED;
						end
					end
				end
				frp_pkg::FRP_TRY: begin
					// attempt lasts one delay period; fault ends it
					if (fault_s2) begin
						next_en    = 1'b0;
						next_state = frp_pkg::FRP_WAIT;
					end else if (tif.done) begin
						next_latch = 1'b0;
						next_cnt   = 3'h0;
						next_state = frp_pkg::FRP_RUN;
					end
				end
				frp_pkg::FRP_LATCHED: begin
					next_en = 1'b0;
				end
				frp_pkg::FRP_HOLD: begin
					next_en = 1'b0;
					if (!fault_s2) begin
						next_en    = 1'b1;
						next_state = frp_pkg::FRP_RUN;
					end
				end
				default: begin
					next_state = frp_pkg::FRP_RUN;
				end
			endcase
		end
	end

	assign tif.start = tstart;
	assign tif.clear = tclear;
	assign tif.exp   = cfg[frp_pkg::DELAY_HI:frp_pkg::DELAY_LO];
	assign tif.unit  = unit;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= frp_pkg::FRP_RUN;
			cnt   <= 3'h0;
			en    <= 1'b1;
			latch <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			en    <= next_en;
			latch <= next_latch;
		end
	end

	// ************************************
	// outputs
	// ************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_rdata     <= 8'h00;
			out_enable    <= 1'b0;
			fault_latched <= 1'b0;
			attempts      <= 3'h0;
			state_out     <= 3'h0;
		end else begin
			cfg_rdata     <= cfg;
			out_enable    <= en;
			fault_latched <= latch;
			attempts      <= cnt;
			state_out     <= state;
		end
	end
endmodule : frp_policy

// >>> frp_host.sv
// host model that writes the fault configuration registers
`timescale 1ns/100ps
module frp_host (
	input  wire logic   sys_clk,
	output logic        cfg_we,
	output logic [7:0]  cfg_cmd,
	output logic [15:0] cfg_wdata
);
	initial begin
		cfg_we = 1'b0;
		cfg_cmd = 8'h00;
		cfg_wdata = 16'h0000;
	end
	task write(input logic [7:0] cmd, input logic [15:0] data);
		cfg_we = 1'b1;
		cfg_cmd = cmd;
		cfg_wdata = data;
		@(posedge sys_clk);
		#1;
		cfg_we = 1'b0;
		// released bus shows no stale value
		cfg_cmd = ~cmd;
		cfg_wdata = ~data;
	endtask : write
endmodule : frp_host

// >>> frp_policy_properties.sv
// assertions for the fault response policy block
`timescale 1ns/100ps
module frp_policy_properties (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        fault_pin,
	input wire logic        cfg_we,
	input wire logic [7:0]  cfg_cmd,
	input wire logic [15:0] cfg_wdata,
	input wire logic        fault_clear,
	input wire logic [7:0]  cfg_rdata,
	input wire logic        out_enable,
	input wire logic        fault_latched,
	input wire logic [2:0]  attempts,
	input wire logic [2:0]  state_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_cfg_readback: assert property (
		cfg_we && cfg_cmd != frp_pkg::TIMING_CMD
		|-> ##2 cfg_rdata == $past(cfg_wdata[7:0], 2)) else $error("bad readback");
	a_ignore_stays_on: assert property (
		cfg_rdata[7:6] == frp_pkg::RESP_IGNORE && out_enable
		|=> out_enable || cfg_rdata[7:6] != frp_pkg::RESP_IGNORE)
		else $error("ignore dropped output");
	// latch stays set through an attempt; only the attempt may enable
	a_latch_off: assert property (
		fault_latched && state_out != frp_pkg::FRP_TRY |-> !out_enable)
		else $error("latched but enabled");
	a_clear_resets: assert property (
		fault_clear |-> ##[1:2] (attempts == 3'h0 && !fault_latched))
		else $error("clear ignored");
	a_shutdown_fast: assert property (
		$rose(fault_pin) && cfg_rdata[7:6] == frp_pkg::RESP_SHUTDN
		|-> ##[1:4] !out_enable) else $error("slow shutdown");
	a_resume_holds_off: assert property (
		fault_pin [*6] ##0 cfg_rdata[7:6] == frp_pkg::RESP_RESUME
		|-> !out_enable) else $error("on while faulted");
	a_attempt_cap: assert property (
		cfg_rdata[5:3] != frp_pkg::RETRY_FOREVER |-> attempts <= cfg_rdata[5:3])
		else $error("too many attempts");
	a_attempt_step: assert property (
		$changed(attempts)
		|-> attempts == 3'h0 || attempts == $past(attempts) + 3'h1)
		else $error("attempt count jumped");
	a_unit_apart: assert property (
		cfg_we && cfg_cmd == frp_pkg::TIMING_CMD ##1 !cfg_we
		|-> ##1 $stable(cfg_rdata)) else $error("unit write hit config");
	c_gave_up: cover property (fault_latched && attempts == 3'h2);
	c_resumed: cover property ($rose(out_enable) && cfg_rdata[7:6] == 2'h3);
	c_retry_live: cover property (out_enable && fault_latched);
endmodule : frp_policy_properties
bind frp_policy frp_policy_properties i_frp_policy_properties (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .fault_pin(fault_pin),
	.cfg_we(cfg_we), .cfg_cmd(cfg_cmd), .cfg_wdata(cfg_wdata),
	.fault_clear(fault_clear), .cfg_rdata(cfg_rdata),
	.out_enable(out_enable), .fault_latched(fault_latched),
	.attempts(attempts), .state_out(state_out));

// >>> test_fault_response_policy.sv
// testbench for the fault response policy block
`timescale 1ns/100ps
module test_fault_response_policy;
	logic        sys_clk = 0, sys_rst = 1, fault_pin = 0, cmd_on = 1;
	logic        fault_clear = 0, cfg_we, out_enable, fault_latched;
	logic [7:0]  cfg_cmd, cfg_rdata;
	logic [15:0] cfg_wdata;
	logic [2:0]  attempts, state_out;
	int          fail_count = 0, checks = 0, ticks = 0;
	always #5 sys_clk = ~sys_clk;
	frp_host i_frp_host (.sys_clk(sys_clk), .cfg_we(cfg_we),
		.cfg_cmd(cfg_cmd), .cfg_wdata(cfg_wdata));
	frp_policy i_frp_policy (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.fault_pin(fault_pin), .cfg_we(cfg_we), .cfg_cmd(cfg_cmd),
		.cfg_wdata(cfg_wdata), .cmd_on(cmd_on), .bias_ok(1'b1),
		.other_fault(1'b0), .fault_clear(fault_clear),
		.cfg_rdata(cfg_rdata), .out_enable(out_enable),
		.fault_latched(fault_latched), .attempts(attempts),
		.state_out(state_out));
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task chk(input logic ok);
		checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t output mismatch", $time);
		end
	endtask : chk
	task wrap_up;
		if (fail_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	// clear first so the old count never meets the new limit
	task setup(input logic [7:0] cfg);
		fault_pin = 0;
		cyc(4);
		fault_clear = 1;
		cyc(1);
		fault_clear = 0;
		i_frp_host.write(8'h00, {8'h00, cfg});
		cyc(3);
	endtask : setup
	task wait_latch;
		// the latch flag rises at shutdown; wait for the final off state
		for (int i = 0; i < 400 && state_out !== frp_pkg::FRP_LATCHED;
			i++) cyc(1);
	endtask : wait_latch
	always @(posedge sys_clk) begin
		ticks++;
		if (ticks == 6000) begin
			fail_count++;
			wrap_up();
		end
	end
	// later scenarios run with a unit of two cycles
	task t_config;
		setup(8'h5A);
		chk(cfg_rdata === 8'h5A);
		i_frp_host.write(frp_pkg::TIMING_CMD, 16'h0002);
		cyc(3);
		chk(cfg_rdata === 8'h5A);
	endtask : t_config
	task t_ignore;
		setup(8'h11);
		fault_pin = 1;
		repeat (40) begin
			cyc(1);
			chk(out_enable === 1'b1);
		end
	endtask : t_ignore
	task t_retry_twice;
		setup(8'h91);
		fault_pin = 1;
		cyc(4);
		chk(out_enable === 1'b0);
		wait_latch();
		chk(fault_latched === 1'b1 && attempts === 3'h2);
		chk(out_enable === 1'b0);
	endtask : t_retry_twice
	task t_no_retry;
		setup(8'h81);
		fault_pin = 1;
		wait_latch();
		fault_pin = 0;
		cyc(20);
		chk(out_enable === 1'b0 && attempts === 3'h0);
		fault_clear = 1;
		cyc(1);
		fault_clear = 0;
		cyc(3);
		chk(out_enable === 1'b1 && fault_latched === 1'b0);
	endtask : t_no_retry
	task t_resume;
		setup(8'hC1);
		fault_pin = 1;
		cyc(6);
		chk(out_enable === 1'b0);
		fault_pin = 0;
		cyc(6);
		chk(out_enable === 1'b1);
	endtask : t_resume
	task t_delay_expire;
		setup(8'h43);
		fault_pin = 1;
		cyc(14);
		chk(out_enable === 1'b1);
		cyc(10);
		chk(out_enable === 1'b0);
	endtask : t_delay_expire
	task t_delay_recover;
		setup(8'h43);
		fault_pin = 1;
		cyc(8);
		fault_pin = 0;
		cyc(30);
		chk(out_enable === 1'b1);
	endtask : t_delay_recover
	// more enabled cycles than any limited count allows
	task t_retry_forever;
		int pulses;
		pulses = 0;
		setup(8'hB8);
		fault_pin = 1;
		repeat (300) begin
			cyc(1);
			if (out_enable === 1'b1) pulses++;
		end
		chk(pulses > 6 && state_out !== frp_pkg::FRP_LATCHED);
		cmd_on = 0;
		cyc(40);
		chk(out_enable === 1'b0);
		chk(state_out === frp_pkg::FRP_LATCHED);
		cmd_on = 1;
	endtask : t_retry_forever
	initial begin
		cyc(10);
		sys_rst = 0;
		cyc(3);
		t_config();
		t_ignore();
		t_retry_twice();
		t_no_retry();
		t_resume();
		t_delay_expire();
		t_delay_recover();
		t_retry_forever();
		wrap_up();
	end
endmodule : test_fault_response_policy
